// File: logic/sys_cmd_pkg.sv
//
// Behaviour
// - power-on source is reset, preset or saved slot; query returns its token
// - saved slot accepted only if the fitted memory option holds it
// - reset and preset sources both start in reset defaults, since the same reset returns the source to reset
// - saved-slot source starts in reset defaults, since the same reset clears every slot's valid flag
// - preset command loads front-panel defaults
// - input switch query answers 1 for front, 0 for rear
// - version query answers the command-language year code, 1991.0
// - message queue is FIFO of ten; each read pops the oldest
// - when full, overflow code 350 sits in the final slot
// - empty queue read answers code 0, no error
// - queue emptied at power-up and clear-status only
// - message codes are signed: negative standard, positive maker-defined
// - zero measured every 200 ms in normal type, every conversion otherwise
// - conversions use reference and zero; zero skipped when correction off
// - zero type normal after reset and preset; power-up takes reset defaults
// - zero type query answers normal or per-reading token
// - key code 1 to 31 accepted and acted on; query returns last key
// - mains sync setting on or off, reported as 1 or 0
// - four acquisition methods kept and reported
// - fetch format is standard or latest-reading
package sys_cmd_pkg;

	// ****************************************
	// command port
	// ****************************************
	localparam int ADDR_W = 4;
	localparam logic [3:0] A_PRESET = 4'h0;
	localparam logic [3:0] A_POWER_ON = 4'h1;
	localparam logic [3:0] A_SWITCH = 4'h2;
	localparam logic [3:0] A_VERSION = 4'h3;
	localparam logic [3:0] A_QUEUE = 4'h4;
	localparam logic [3:0] A_CLEAR = 4'h5;
	localparam logic [3:0] A_ZERO = 4'h6;
	localparam logic [3:0] A_MAINS = 4'h7;
	localparam logic [3:0] A_KEY = 4'h8;
	localparam logic [3:0] A_METHOD = 4'h9;
	localparam logic [3:0] A_FETCH = 4'hA;
	localparam logic [3:0] A_CONFIG = 4'hB;

	// ****************************************
	// encodings and values
	// ****************************************
	localparam logic [3:0] SRC_RESET = 4'hA;
	localparam logic [3:0] SRC_PRESET = 4'hB;
	localparam logic [1:0] MEM_BASIC = 2'h0;
	localparam logic [1:0] MEM_MEDIUM = 2'h1;
	localparam logic [1:0] MEM_LARGE = 2'h2;
	localparam logic [3:0] MAX_SLOT_BASIC = 4'h0;
	localparam logic [3:0] MAX_SLOT_MEDIUM = 4'h4;
	localparam logic [3:0] MAX_SLOT_LARGE = 4'h9;
	localparam int NUM_SLOTS = 10;
	localparam logic [15:0] VERSION_YEAR = 16'h07C7;
	localparam logic [3:0] VERSION_MINOR = 4'h0;
	localparam int QUEUE_DEPTH = 10;
	localparam logic signed [15:0] CODE_OVERFLOW = 16'sh015E;
	localparam logic signed [15:0] CODE_NO_ERROR = 16'sh0000;
	localparam logic [4:0] KEY_MIN = 5'h01;
	localparam logic [4:0] KEY_MAX = 5'h1F;
	localparam logic [4:0] KEY_RESET = 5'h00;
	localparam logic [3:0] POWER_ON_RESET = SRC_RESET;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ = 10_000_000;
	localparam int ZERO_PERIOD_MS = 200;
	localparam int ZERO_PERIOD_CYC = CLK_HZ / 1000 * ZERO_PERIOD_MS;

	typedef enum logic [1:0] {M_NORMAL, M_BURST, M_TEXT_STREAM, M_BINARY_STREAM} method_e;
	typedef enum logic {Z_NORMAL, Z_PER_READING} zero_type_e;
	typedef enum logic {F_STANDARD, F_LATEST} fetch_e;

	// ****************************************
	// configuration that a setup holds
	// ****************************************
	typedef struct packed {
		logic zero_en;
		zero_type_e zero_type;
		logic mains_sync;
		method_e method;
		fetch_e fetch_fmt;
	} setup_s;

	// reset defaults, preset defaults (preset favours front panel)
	localparam setup_s SETUP_RESET = '{1'b1, Z_NORMAL, 1'b1, M_NORMAL, F_STANDARD};
	localparam setup_s SETUP_PRESET = '{1'b1, Z_NORMAL, 1'b1, M_NORMAL, F_LATEST};

	// conversion phase strobes
	typedef struct packed {
		logic reference;
		logic zero;
		logic signal;
	} phase_s;

endpackage : sys_cmd_pkg

// File: logic/system_command_handler.sv
`timescale 1ns/1ps
module system_command_handler #(
	parameter int ZERO_PERIOD = sys_cmd_pkg::ZERO_PERIOD_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// command port
	input wire logic [3:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// command events
	input wire logic save_i,
	input wire logic [3:0] save_slot_i,
	input wire logic clear_status_i,
	input wire logic msg_valid_i,
	input wire logic signed [15:0] msg_code_i,
	// instrument inputs
	input wire logic front_inputs_i,
	input wire logic [1:0] mem_option_i,
	input wire logic conv_start_i,
	// instrument outputs
	output sys_cmd_pkg::setup_s setup_o,
	output sys_cmd_pkg::phase_s phase_o,
	output logic key_press_o,
	output logic [4:0] key_code_o,
	output logic [3:0] queue_count_o
);

	// ****************************************
	// state
	// ****************************************
	sys_cmd_pkg::setup_s setup_reg;
	sys_cmd_pkg::setup_s slot_mem [sys_cmd_pkg::NUM_SLOTS];
	logic [sys_cmd_pkg::NUM_SLOTS-1:0] slot_valid_reg;
	logic [3:0] power_on_reg;
	logic boot_reg;
	logic [4:0] key_reg;
	logic key_press_reg;
	logic signed [15:0] queue_mem [sys_cmd_pkg::QUEUE_DEPTH];
	logic [3:0] rd_ptr_reg;
	logic [3:0] wr_ptr_reg;
	logic [3:0] count_reg;
	logic [23:0] zero_timer_reg;
	logic zero_due_reg;
	logic [1:0] conv_step_reg;
	logic [31:0] rdata_reg;
	sys_cmd_pkg::phase_s phase_reg;

	// slot limit of the fitted memory option
	function automatic logic slot_ok(input logic [3:0] slot, input logic [1:0] opt);
		logic [3:0] lim;
		lim = sys_cmd_pkg::MAX_SLOT_BASIC;
		case (opt)
			sys_cmd_pkg::MEM_MEDIUM: lim = sys_cmd_pkg::MAX_SLOT_MEDIUM;
			sys_cmd_pkg::MEM_LARGE: lim = sys_cmd_pkg::MAX_SLOT_LARGE;
			default: lim = sys_cmd_pkg::MAX_SLOT_BASIC;
		endcase
		slot_ok = (slot <= lim);
	endfunction : slot_ok

	function automatic logic [3:0] ptr_inc(input logic [3:0] p);
		ptr_inc = (p == 4'(sys_cmd_pkg::QUEUE_DEPTH - 1)) ? 4'h0 : p + 4'h1;
	endfunction : ptr_inc

	logic wr_sel_ok;
	logic q_pop;
	logic q_push;
	logic [3:0] wr_val;
	assign wr_val = wdata_i[3:0];
	assign wr_sel_ok = (wr_val == sys_cmd_pkg::SRC_RESET) || (wr_val == sys_cmd_pkg::SRC_PRESET)
		|| (wr_val <= sys_cmd_pkg::MAX_SLOT_LARGE && slot_ok(wr_val, mem_option_i));
	assign q_pop = rd_i && addr_i == sys_cmd_pkg::A_QUEUE && count_reg != 4'h0;
	// drop while full
	// a same-cycle read frees room only from the next cycle on
	assign q_push = msg_valid_i && count_reg < 4'(sys_cmd_pkg::QUEUE_DEPTH);

	// ****************************************
	// power-on source select
	// ****************************************
	// source select
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			power_on_reg <= sys_cmd_pkg::POWER_ON_RESET;
		end else if (wr_i && addr_i == sys_cmd_pkg::A_POWER_ON && wr_sel_ok) begin
			power_on_reg <= wr_val;
		end
	end

	// saved setups, written by the save command
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			slot_valid_reg <= '0;
		end else if (save_i && save_slot_i <= sys_cmd_pkg::MAX_SLOT_LARGE
			&& slot_ok(save_slot_i, mem_option_i)) begin
			slot_valid_reg[save_slot_i] <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (save_i && save_slot_i <= sys_cmd_pkg::MAX_SLOT_LARGE) begin
			slot_mem[save_slot_i] <= setup_reg;
		end
	end

	// ****************************************
	// live setup
	// ****************************************
	// boot flag: the configuration is loaded one cycle after reset release,
	// since a register may not take the selected slot under reset
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			boot_reg <= 1'b1;
		end else begin
			boot_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			setup_reg <= sys_cmd_pkg::SETUP_RESET;
		end else if (boot_reg) begin
			if (power_on_reg == sys_cmd_pkg::SRC_PRESET) begin
				setup_reg <= sys_cmd_pkg::SETUP_PRESET;
			end else if (power_on_reg <= sys_cmd_pkg::MAX_SLOT_LARGE
				&& slot_valid_reg[power_on_reg]) begin
				setup_reg <= slot_mem[power_on_reg];
			end else begin
				setup_reg <= sys_cmd_pkg::SETUP_RESET;
			end
		end else if (wr_i && addr_i == sys_cmd_pkg::A_PRESET) begin
			setup_reg <= sys_cmd_pkg::SETUP_PRESET;
		end else if (wr_i && addr_i == sys_cmd_pkg::A_ZERO) begin
			setup_reg.zero_type <= sys_cmd_pkg::zero_type_e'(wdata_i[0]);
			setup_reg.zero_en <= wdata_i[1];
		end else if (wr_i && addr_i == sys_cmd_pkg::A_MAINS) begin
			setup_reg.mains_sync <= wdata_i[0];
		end else if (wr_i && addr_i == sys_cmd_pkg::A_METHOD) begin
			setup_reg.method <= sys_cmd_pkg::method_e'(wdata_i[1:0]);
		end else if (wr_i && addr_i == sys_cmd_pkg::A_FETCH) begin
			setup_reg.fetch_fmt <= sys_cmd_pkg::fetch_e'(wdata_i[0]);
		end
	end

	// ****************************************
	// simulated key press
	// ****************************************
	// key accept
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			key_reg <= sys_cmd_pkg::KEY_RESET;
			key_press_reg <= 1'b0;
		end else begin
			key_press_reg <= 1'b0;
			if (wr_i && addr_i == sys_cmd_pkg::A_KEY && wdata_i[31:5] == '0
				&& wdata_i[4:0] >= sys_cmd_pkg::KEY_MIN) begin
				key_reg <= wdata_i[4:0];
				key_press_reg <= 1'b1;
			end
		end
	end

	// ****************************************
	// message queue
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (q_push) begin
			if (count_reg - {3'h0, q_pop} == 4'(sys_cmd_pkg::QUEUE_DEPTH - 1)) begin
				queue_mem[wr_ptr_reg] <= sys_cmd_pkg::CODE_OVERFLOW;
			end else begin
				queue_mem[wr_ptr_reg] <= msg_code_i;
			end
		end
	end

	// clear on power-up and clear-status only
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_ptr_reg <= 4'h0;
			wr_ptr_reg <= 4'h0;
			count_reg <= 4'h0;
		end else if (clear_status_i || (wr_i && addr_i == sys_cmd_pkg::A_CLEAR)) begin
			rd_ptr_reg <= 4'h0;
			wr_ptr_reg <= 4'h0;
			count_reg <= 4'h0;
		end else begin
			if (q_pop) begin
				rd_ptr_reg <= ptr_inc(rd_ptr_reg);
			end
			if (q_push) begin
				wr_ptr_reg <= ptr_inc(wr_ptr_reg);
			end
			count_reg <= count_reg + {3'h0, q_push} - {3'h0, q_pop};
		end
	end

	// ****************************************
	// zero correction schedule
	// ****************************************
	// 200 ms timer
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			zero_timer_reg <= '0;
			zero_due_reg <= 1'b1;
		end else begin
			if (phase_reg.zero) begin
				zero_due_reg <= 1'b0;
			end
			// tick placed last so that it wins over a same-cycle clear
			if (zero_timer_reg == 24'(ZERO_PERIOD - 1)) begin
				zero_timer_reg <= '0;
				zero_due_reg <= 1'b1;
			end else begin
				zero_timer_reg <= zero_timer_reg + 24'h1;
			end
		end
	end

	// conversion: reference, then zero when due, then signal
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			conv_step_reg <= 2'h0;
			phase_reg <= '0;
		end else begin
			phase_reg <= '0;
			case (conv_step_reg)
				2'h0: begin
					if (conv_start_i) begin
						phase_reg.reference <= 1'b1;
						conv_step_reg <= 2'h1;
					end
				end
				2'h1: begin
					if (setup_reg.zero_en && (setup_reg.zero_type == sys_cmd_pkg::Z_PER_READING
						|| zero_due_reg)) begin
						phase_reg.zero <= 1'b1;
					end
					conv_step_reg <= 2'h2;
				end
				2'h2: begin
					phase_reg.signal <= 1'b1;
					conv_step_reg <= 2'h0;
				end
				default: conv_step_reg <= 2'h0;
			endcase
		end
	end

	// ****************************************
	// queries
	// ****************************************
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_reg <= '0;
		end else if (rd_i) begin
			case (addr_i)
				sys_cmd_pkg::A_POWER_ON: rdata_reg <= {28'h0, power_on_reg};
				sys_cmd_pkg::A_SWITCH: rdata_reg <= {31'h0, front_inputs_i};
				sys_cmd_pkg::A_VERSION: rdata_reg <= {12'h0, sys_cmd_pkg::VERSION_YEAR,
					sys_cmd_pkg::VERSION_MINOR};
				sys_cmd_pkg::A_QUEUE: begin
					if (count_reg == 4'h0) begin
						rdata_reg <= {{16{sys_cmd_pkg::CODE_NO_ERROR[15]}},
							sys_cmd_pkg::CODE_NO_ERROR};
					end else begin
						rdata_reg <= {{16{queue_mem[rd_ptr_reg][15]}}, queue_mem[rd_ptr_reg]};
					end
				end
				sys_cmd_pkg::A_ZERO: rdata_reg <= {30'h0, setup_reg.zero_en, setup_reg.zero_type};
				sys_cmd_pkg::A_MAINS: rdata_reg <= {31'h0, setup_reg.mains_sync};
				sys_cmd_pkg::A_KEY: rdata_reg <= {27'h0, key_reg};
				sys_cmd_pkg::A_METHOD: rdata_reg <= {30'h0, setup_reg.method};
				sys_cmd_pkg::A_FETCH: rdata_reg <= {31'h0, setup_reg.fetch_fmt};
				sys_cmd_pkg::A_CONFIG: rdata_reg <= {22'h0, slot_valid_reg};
				default: rdata_reg <= '0;
			endcase
		end else begin
			rdata_reg <= '0;
		end
	end

	// outputs
	assign rdata_o = rdata_reg;
	assign setup_o = setup_reg;
	assign phase_o = phase_reg;
	assign key_press_o = key_press_reg;
	assign key_code_o = key_reg;
	assign queue_count_o = count_reg;

endmodule : system_command_handler

// File: verification/sys_cmd_assertions.sv
`timescale 1ns/1ps
// ********
// handler port checks
// ********
module sys_cmd_checker (
	// clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// command port
	input wire logic [3:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	// events and outputs
	input wire logic clear_status_i,
	input wire logic msg_valid_i,
	input wire logic conv_start_i,
	input wire sys_cmd_pkg::setup_s setup_o,
	input wire sys_cmd_pkg::phase_s phase_o,
	input wire logic key_press_o,
	input wire logic [4:0] key_code_o,
	input wire logic [3:0] queue_count_o
);
	// one domain, so one clocking and one disable
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);

	property p_version;
		rd_i && addr_i == sys_cmd_pkg::A_VERSION |=> rdata_o == 32'h00007C70;
	endproperty
	a_version: assert property (p_version) else $error("version code wrong");
	property p_empty;
		rd_i && addr_i == sys_cmd_pkg::A_QUEUE && queue_count_o == 4'h0 |=> rdata_o == 32'h0;
	endproperty
	a_empty: assert property (p_empty) else $error("empty read not zero");
	property p_pop;
		rd_i && addr_i == sys_cmd_pkg::A_QUEUE && queue_count_o != 4'h0 && !msg_valid_i
			&& !clear_status_i |=> queue_count_o == $past(queue_count_o) - 4'h1;
	endproperty
	a_pop: assert property (p_pop) else $error("read did not remove entry");
	property p_clear;
		clear_status_i |=> queue_count_o == 4'h0 ##1 (queue_count_o == 4'h0 || $past(msg_valid_i));
	endproperty
	a_clear: assert property (p_clear) else $error("clear left entries");
	property p_conv;
		conv_start_i |=> phase_o.reference ##2 phase_o.signal;
	endproperty
	a_conv: assert property (p_conv) else $error("conversion phases wrong");
	property p_sync_zero;
		conv_start_i && setup_o.zero_en && setup_o.zero_type == sys_cmd_pkg::Z_PER_READING
			|-> ##2 phase_o.zero;
	endproperty
	a_sync_zero: assert property (p_sync_zero) else $error("zero phase missing");
	property p_key;
		wr_i && addr_i == sys_cmd_pkg::A_KEY && wdata_i inside {[1:31]}
			|=> key_press_o && key_code_o == $past(wdata_i[4:0]);
	endproperty
	a_key: assert property (p_key) else $error("key press not taken");
	property p_preset;
		wr_i && addr_i == sys_cmd_pkg::A_PRESET |=> setup_o == sys_cmd_pkg::SETUP_PRESET;
	endproperty
	a_preset: assert property (p_preset) else $error("preset defaults not loaded");
	// main scenarios reached
	c_full: cover property (queue_count_o == 4'hA);
	c_zero: cover property (phase_o.zero);
	c_key: cover property (key_press_o);
endmodule : sys_cmd_checker

// File: verification/bus_host.sv
`timescale 1ns/1ps
// ********
// host bus controller
// ********
module bus_host (
	// clock and answer
	input wire logic clk_i,
	input wire logic [31:0] rdata_i,
	// request
	output logic [3:0] addr_o,
	output logic [31:0] wdata_o,
	output logic wr_o,
	output logic rd_o
);
	// idle bus until the first command
	initial begin
		addr_o = 4'h0;
		wdata_o = 32'h0;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// one-cycle write strobe
	task automatic write(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= v;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
	endtask : write
	// data stands only in the cycle after the strobe
	task automatic read(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		#1;
		v = rdata_i;
	endtask : read
endmodule : bus_host

// File: verification/testbench.sv
`timescale 1ns/1ps
`define CHK(what, exp, got) begin \
	n_compared++; \
	if ((got) !== (exp)) begin \
		bad_count++; \
		$display("Error %s expected %0h seen %0h", what, exp, got); \
	end \
end
module testbench;
	// ********
	// wiring
	// ********
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [3:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	logic msg_valid_i = 1'b0;
	logic signed [15:0] msg_code_i = 16'sh0000;
	logic clear_status_i = 1'b0;
	logic front_inputs_i = 1'b0;
	logic [1:0] mem_option_i = 2'h0;
	logic conv_start_i = 1'b0;
	logic save_i = 1'b0;
	logic [3:0] save_slot_i = 4'h0;
	sys_cmd_pkg::setup_s setup_o;
	sys_cmd_pkg::phase_s phase_o;
	logic key_press_o;
	logic [4:0] key_code_o;
	logic [3:0] queue_count_o;
	logic [31:0] d;
	int bad_count = 0;
	int n_compared = 0;
	int cycles = 0;
	int zeros = 0;
	int refs = 0;
	// option[9:8], requested source[7:4], expected answer[3:0]
	localparam logic [9:0] PO_TBL [7] = '{10'h04A, 10'h000, 10'h144, 10'h154, 10'h299,
		10'h2C9, 10'h2BB};

	always #50 clk_i = ~clk_i;

	bus_host host (.clk_i, .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
		.rd_o(rd));
	system_command_handler #(.ZERO_PERIOD(20)) uut (.clk_i, .arst_n_i, .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .save_i,
		.save_slot_i, .clear_status_i, .msg_valid_i, .msg_code_i, .front_inputs_i,
		.mem_option_i, .conv_start_i, .setup_o, .phase_o, .key_press_o, .key_code_o,
		.queue_count_o);

	// phases counted off the edge; hang cut short
	always @(negedge clk_i) begin
		cycles++;
		zeros += phase_o.zero;
		refs += phase_o.reference;
		if (cycles == 6000) begin
			bad_count++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test

	task automatic push(input logic signed [15:0] c);
		@(posedge clk_i);
		msg_valid_i <= 1'b1;
		msg_code_i <= c;
		@(posedge clk_i);
		msg_valid_i <= 1'b0;
	endtask : push

	// four cycles apart, so phases never overlap
	task automatic conv(input int n);
		repeat (n) begin
			@(posedge clk_i);
			conv_start_i <= 1'b1;
			@(posedge clk_i);
			conv_start_i <= 1'b0;
			repeat (2) @(posedge clk_i);
		end
		repeat (3) @(posedge clk_i);
	endtask : conv

	task automatic t_basic();
		`CHK("setup", sys_cmd_pkg::SETUP_RESET, setup_o)
		host.read(sys_cmd_pkg::A_POWER_ON, d);
		`CHK("power-on", 32'hA, d)
		host.read(sys_cmd_pkg::A_VERSION, d);
		`CHK("version", 32'h00007C70, d)
		for (int f = 0; f < 2; f++) begin
			@(posedge clk_i);
			front_inputs_i <= f[0];
			host.read(sys_cmd_pkg::A_SWITCH, d);
			`CHK("switch", {31'h0, f[0]}, d)
		end
	endtask : t_basic

	task automatic t_power_on();
		for (int i = 0; i < 7; i++) begin
			@(posedge clk_i);
			mem_option_i <= PO_TBL[i][9:8];
			host.write(sys_cmd_pkg::A_POWER_ON, {28'h0, PO_TBL[i][7:4]});
			host.read(sys_cmd_pkg::A_POWER_ON, d);
			`CHK("power-on", {28'h0, PO_TBL[i][3:0]}, d)
		end
	endtask : t_power_on

	task automatic t_save();
		for (int s = 4; s < 6; s++) begin
			@(posedge clk_i);
			mem_option_i <= sys_cmd_pkg::MEM_MEDIUM;
			save_i <= 1'b1;
			save_slot_i <= s[3:0];
			@(posedge clk_i);
			save_i <= 1'b0;
		end
		host.read(sys_cmd_pkg::A_CONFIG, d);
		`CHK("saved", 32'h010, d)
	endtask : t_save

	task automatic t_queue();
		push(-16'sd5);
		push(16'sd7);
		host.read(sys_cmd_pkg::A_QUEUE, d);
		`CHK("queue", 32'hFFFFFFFB, d)
		host.read(sys_cmd_pkg::A_QUEUE, d);
		`CHK("queue", 32'h7, d)
		for (int i = 1; i <= 12; i++) push(i[15:0]);
		@(negedge clk_i);
		`CHK("count", 4'hA, queue_count_o)
		for (int i = 1; i <= 10; i++) begin
			host.read(sys_cmd_pkg::A_QUEUE, d);
			`CHK("queue", (i == 10) ? 32'd350 : i, d)
		end
		host.read(sys_cmd_pkg::A_QUEUE, d);
		`CHK("queue", 32'h0, d)
		push(16'sd3);
		@(posedge clk_i);
		clear_status_i <= 1'b1;
		@(posedge clk_i);
		clear_status_i <= 1'b0;
		host.read(sys_cmd_pkg::A_QUEUE, d);
		`CHK("queue", 32'h0, d)
		push(16'sd4);
		host.write(sys_cmd_pkg::A_PRESET, 32'h0);
		@(negedge clk_i);
		`CHK("count", 4'h1, queue_count_o)
		host.write(sys_cmd_pkg::A_CLEAR, 32'h0);
		@(negedge clk_i);
		`CHK("count", 4'h0, queue_count_o)
	endtask : t_queue

	task automatic t_settings();
		host.write(sys_cmd_pkg::A_ZERO, 32'h3);
		host.write(sys_cmd_pkg::A_PRESET, 32'h0);
		@(negedge clk_i);
		`CHK("setup", sys_cmd_pkg::SETUP_PRESET, setup_o)
		host.read(sys_cmd_pkg::A_ZERO, d);
		`CHK("zero type", 32'h2, d)
		for (int m = 0; m < 4; m++) begin
			host.write(sys_cmd_pkg::A_METHOD, m);
			@(negedge clk_i);
			`CHK("method", m[1:0], setup_o.method)
		end
		host.write(sys_cmd_pkg::A_MAINS, 32'h0);
		host.write(sys_cmd_pkg::A_FETCH, 32'h0);
		@(negedge clk_i);
		`CHK("mains", 1'b0, setup_o.mains_sync)
		`CHK("fetch", sys_cmd_pkg::F_STANDARD, setup_o.fetch_fmt)
		for (int k = 0; k < 4; k++) begin
			host.write(sys_cmd_pkg::A_KEY, (k == 3) ? 32 : (k == 2) ? 31 : 5 - 5 * k);
			@(negedge clk_i);
			`CHK("key", (k < 2) ? 5'h05 : 5'h1F, key_code_o)
			`CHK("press", ~k[0], key_press_o)
		end
		host.read(sys_cmd_pkg::A_KEY, d);
		`CHK("key query", 32'h1F, d)
		host.read(sys_cmd_pkg::A_METHOD, d);
		`CHK("method query", 32'h3, d)
		host.read(sys_cmd_pkg::A_MAINS, d);
		`CHK("mains query", 32'h0, d)
		host.read(sys_cmd_pkg::A_FETCH, d);
		`CHK("fetch query", 32'h0, d)
	endtask : t_settings

	task automatic t_zero();
		host.write(sys_cmd_pkg::A_ZERO, 32'h2);
		zeros = 0;
		refs = 0;
		conv(15);
		`CHK("zero normal", 1'b1, zeros inside {3, 4})
		`CHK("reference", 15, refs)
		host.write(sys_cmd_pkg::A_ZERO, 32'h3);
		host.read(sys_cmd_pkg::A_ZERO, d);
		`CHK("zero type", 32'h3, d)
		zeros = 0;
		conv(5);
		`CHK("zero sync", 5, zeros)
		host.write(sys_cmd_pkg::A_ZERO, 32'h0);
		zeros = 0;
		conv(5);
		`CHK("zero off", 0, zeros)
	endtask : t_zero

	// reset, then scenarios in turn
	initial begin
		repeat (8) @(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		t_basic();
		t_power_on();
		t_save();
		t_queue();
		t_settings();
		t_zero();
		finish_test();
	end
endmodule : testbench

bind system_command_handler sys_cmd_checker chk (.clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i,
	.rd_i, .rdata_o, .clear_status_i, .msg_valid_i, .conv_start_i, .setup_o, .phase_o,
	.key_press_o, .key_code_o, .queue_count_o);
